// File: core/tmr1_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmr1_regs.svh"
// Contract
// - 8-bit up counter wraps max to zero, keeps counting, flags time-out.
// - Mode bit 3 picks internal prescaled clock (0) or event pin (1).
// - External mode advances counter once per falling edge on event pin.
// - Rate bits 6..4 divide clock by 256 at 000 down to 2 at 111.
// - External mode ignores rate and holds event pin request flag at 0.
// - Mode bit 7 enables counting when 1, disables timer when 0.
// - Mode bit 0 enables PWM output; reload and toggle bits shape cycle.
// - Without PWM, bit 1 drives toggle onto wave pin, else pin is GPIO.
// - Without PWM, bit 2 enables reload from reload register on overflow.
// - Boundary 256, or in PWM with internal clock 256/64/32/16 by reload and toggle bits.
// - With reload active, overflow copies reload value into counter.
// - Reload writes land in a buffer, moved to active at next overflow.
// - PWM forces reload on; reload bit then only selects the boundary.
// - Counter register is 8-bit, readable and writable by software.
// - PWM output high while counter below reference, else low.
// - Toggle output inverts on each overflow, half the overflow rate.
module tmr1_top
    import tmr1_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire tmr1_pkg::tmr1_addr_t PADDR_I,
    input wire tmr1_pkg::tmr1_word_t PWDATA_I,
    output tmr1_pkg::tmr1_word_t PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic EVENT_PORT_PIN_I,
    input wire logic GPIO_DATA_I,
    input wire logic GPIO_OE_I,
    output logic WAVE_OUTPUT_PIN_O,
    output logic WAVE_OUTPUT_PIN_OE_O,
    output logic TIMER_ONE_REQUEST_FLAG_O,
    output logic EVENT_PIN_REQUEST_FLAG_O,
    output logic TIMEOUT_PULSE_O
);
    import tmr1_pkg::*;

    // ==========================================================
    // Register state
    tmr1_byte_t mode;
    tmr1_byte_t count;
    tmr1_byte_t reload_hold;
    tmr1_byte_t reload_active;
    logic toggle;
    logic tmr_flag;
    logic ev_flag;

    // ==========================================================
    // Decoded mode and datapath
    logic run;
    logic ext_src;
    logic aload;
    logic toggle_en;
    logic pwm_en;
    logic reload_on;
    tmr1_rate_t rate;
    tmr1_byte_t mask;
    logic pre_tick;
    logic tick;
    logic overflow;
    logic ev_meta;
    logic ev_sync;
    logic ev_prev;
    logic ev_fall;
    logic access;
    logic wr;
    logic wr_mode;
    logic wr_count;
    logic wr_reload;
    logic wr_status;
    logic next_wave;
    logic next_wave_oe;

    // Byte address of a register from its index
    function automatic logic hit(input tmr1_addr_t a, input tmr1_byte_t idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    // Boundary mask; external clock always counts 256
    function automatic tmr1_byte_t bound_mask(input logic pwm,
                                              input logic ext,
                                              input tmr1_bound_e b);
        if (!pwm || ext) begin
            bound_mask = `TMR1_MASK_256;
        end else begin
            case (b)
                TMR1_BND_256: bound_mask = `TMR1_MASK_256;
                TMR1_BND_64: bound_mask = `TMR1_MASK_64;
                TMR1_BND_32: bound_mask = `TMR1_MASK_32;
                TMR1_BND_16: bound_mask = `TMR1_MASK_16;
                default: bound_mask = `TMR1_MASK_256;
            endcase
        end
    endfunction : bound_mask

    assign run = mode[`TMR1_RUN_BIT];
    assign ext_src = mode[`TMR1_SRC_BIT];
    assign aload = mode[`TMR1_ALOAD_BIT];
    assign toggle_en = mode[`TMR1_TOGGLE_BIT];
    assign pwm_en = mode[`TMR1_PWM_BIT];
    assign rate = mode[`TMR1_RATE_MSB:`TMR1_RATE_LSB];
    // PWM implies reload; the reload bit then only sets the boundary
    assign reload_on = pwm_en || aload;
    assign mask = bound_mask(pwm_en, ext_src,
                             tmr1_bound_e'({aload, toggle_en}));

    // ==========================================================
    // Event pin synchroniser and falling edge detect
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ev_meta <= 1'b1;
            ev_sync <= 1'b1;
            ev_prev <= 1'b1;
        end else if (CE_I) begin
            ev_meta <= EVENT_PORT_PIN_I;
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
        end
    end

    assign ev_fall = ev_prev && !ev_sync;

    // ==========================================================
    // Prescaler runs only for internal counting
    tmr1_prescale u_prescale (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .run_i(run && !ext_src),
        .rate_i(rate),
        .tick_o(pre_tick)
    );

    // Rate is ignored in external mode; nothing moves while stopped
    assign tick = run && (ext_src ? ev_fall : pre_tick);
    assign overflow = tick && ((count & mask) == mask);

    // ==========================================================
    // Register bus decode
    assign access = PSEL_I && PENABLE_I && PREADY_O;
    assign wr = access && PWRITE_I;
    assign wr_mode = wr && hit(PADDR_I, `TMR1_MODE_IDX);
    assign wr_count = wr && hit(PADDR_I, `TMR1_COUNT_IDX);
    assign wr_reload = wr && hit(PADDR_I, `TMR1_RELOAD_IDX);
    assign wr_status = wr && hit(PADDR_I, `TMR1_STATUS_IDX);

    // Answer is prepared in the setup cycle, so no wait states
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else if (CE_I) begin
            PREADY_O <= PSEL_I && !PREADY_O;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            if (PSEL_I && !PREADY_O) begin
                if (hit(PADDR_I, `TMR1_MODE_IDX)) begin
                    PRDATA_O <= {24'h00_0000, mode};
                end else if (hit(PADDR_I, `TMR1_COUNT_IDX)) begin
                    PRDATA_O <= {24'h00_0000, count};
                end else if (hit(PADDR_I, `TMR1_STATUS_IDX)) begin
                    PRDATA_O <= {30'h0000_0000, ev_flag, tmr_flag};
                end else if (!hit(PADDR_I, `TMR1_RELOAD_IDX)) begin
                    PSLVERR_O <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Mode register
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode <= `TMR1_MODE_RST;
        end else if (CE_I && wr_mode) begin
            mode <= PWDATA_I[7:0];
        end
    end

    // ==========================================================
    // Counter; a software write beats a same-cycle count
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            count <= `TMR1_COUNT_RST;
        end else if (CE_I) begin
            if (wr_count) begin
                count <= PWDATA_I[7:0];
            end else if (overflow) begin
                count <= reload_on ? reload_hold : 8'h00;
            end else if (tick) begin
                count <= (count + 8'h01) & mask;
            end
        end
    end

    // ==========================================================
    // Double-buffered reload; the buffer value moves at overflow
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            reload_hold <= `TMR1_RELOAD_RST;
            reload_active <= `TMR1_RELOAD_RST;
        end else if (CE_I) begin
            if (wr_reload) begin
                reload_hold <= PWDATA_I[7:0];
            end
            if (overflow) begin
                reload_active <= reload_hold;
            end
        end
    end

    // ==========================================================
    // Request flags: write one clears, a new event wins the race
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tmr_flag <= 1'b0;
        end else if (CE_I) begin
            if (overflow) begin
                tmr_flag <= 1'b1;
            end else if (wr_status && PWDATA_I[`TMR1_TMR_FLAG_BIT]) begin
                tmr_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ev_flag <= 1'b0;
        end else if (CE_I) begin
            if (ext_src) begin
                ev_flag <= 1'b0;
            end else if (ev_fall) begin
                ev_flag <= 1'b1;
            end else if (wr_status && PWDATA_I[`TMR1_EV_FLAG_BIT]) begin
                ev_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Toggle divides the overflow rate by two
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            toggle <= 1'b0;
        end else if (CE_I && overflow) begin
            toggle <= !toggle;
        end
    end

    // ==========================================================
    // Wave pin: PWM first, then toggle, else the GPIO port
    // Compare uses the live counter against the active reload, so a duty change waits for overflow
    always_comb begin
        if (pwm_en) begin
            next_wave = count < reload_active;
            next_wave_oe = 1'b1;
        end else if (toggle_en) begin
            next_wave = toggle;
            next_wave_oe = 1'b1;
        end else begin
            next_wave = GPIO_DATA_I;
            next_wave_oe = GPIO_OE_I;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            WAVE_OUTPUT_PIN_O <= 1'b0;
            WAVE_OUTPUT_PIN_OE_O <= 1'b0;
            TIMEOUT_PULSE_O <= 1'b0;
            TIMER_ONE_REQUEST_FLAG_O <= 1'b0;
            EVENT_PIN_REQUEST_FLAG_O <= 1'b0;
        end else if (CE_I) begin
            WAVE_OUTPUT_PIN_O <= next_wave;
            WAVE_OUTPUT_PIN_OE_O <= next_wave_oe;
            TIMEOUT_PULSE_O <= overflow;
            TIMER_ONE_REQUEST_FLAG_O <= tmr_flag;
            EVENT_PIN_REQUEST_FLAG_O <= ev_flag;
        end
    end

    // ==========================================================
    // Checks
    sequence count_step_s;
        CE_I && tick && !overflow && !wr_count;
    endsequence

    sequence ovf_plain_s;
        CE_I && overflow && !wr_count;
    endsequence

    ovf_wrap_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (ovf_plain_s and !reload_on) |=> count == 8'h00)
        else $error("overflow did not wrap to zero");

    ovf_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && overflow) ##1 CE_I |=> TIMER_ONE_REQUEST_FLAG_O)
        else $error("overflow flag not shown");

    ext_edge_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (count_step_s and ext_src)
            |=> count == $past(count) + 8'h01)
        else $error("event edge did not advance counter");

    ev_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && ext_src ##1 CE_I |=> !EVENT_PIN_REQUEST_FLAG_O)
        else $error("event flag raised in external mode");

    stop_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && !run && !wr_count |=> $stable(count) && $stable(toggle))
        else $error("stopped timer changed");

    reload_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (ovf_plain_s and reload_on)
            |=> count == $past(reload_hold))
        else $error("reload value not loaded");

    hold_xfer_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && !overflow |=> $stable(reload_active))
        else $error("active reload moved without overflow");

    toggle_flip_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && overflow |=> toggle != $past(toggle))
        else $error("toggle did not invert");

    pwm_level_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && pwm_en |=> WAVE_OUTPUT_PIN_O == $past(count < reload_active)
            && WAVE_OUTPUT_PIN_OE_O)
        else $error("pwm level wrong");

    pwm_bound_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (count_step_s and (pwm_en && !ext_src && aload && toggle_en))
            |=> count == (($past(count) + 8'h01) & 8'h0F))
        else $error("pwm 16 boundary not kept");

    apb_ready_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CE_I && PSEL_I && !PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("no zero-wait answer");
endmodule : tmr1_top
`default_nettype wire

// File: core/tmr1_regs.svh
`ifndef TMR1_REGS_SVH
`define TMR1_REGS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define TMR1_MODE_IDX 8'hDC
`define TMR1_COUNT_IDX 8'hDD
`define TMR1_RELOAD_IDX 8'hDE
`define TMR1_STATUS_IDX 8'hDF
// ==========================================================
// Mode register fields
`define TMR1_RUN_BIT 7
`define TMR1_RATE_MSB 6
`define TMR1_RATE_LSB 4
`define TMR1_SRC_BIT 3
`define TMR1_ALOAD_BIT 2
`define TMR1_TOGGLE_BIT 1
`define TMR1_PWM_BIT 0
// ==========================================================
// Status register fields
`define TMR1_TMR_FLAG_BIT 0
`define TMR1_EV_FLAG_BIT 1
// ==========================================================
// Reset values and boundary masks
`define TMR1_MODE_RST 8'h00
`define TMR1_COUNT_RST 8'h00
`define TMR1_RELOAD_RST 8'h00
`define TMR1_MASK_256 8'hFF
`define TMR1_MASK_64 8'h3F
`define TMR1_MASK_32 8'h1F
`define TMR1_MASK_16 8'h0F
`endif

// File: core/tmr1_pkg.sv
package tmr1_pkg;
    typedef logic [7:0] tmr1_byte_t;
    typedef logic [11:0] tmr1_addr_t;
    typedef logic [31:0] tmr1_word_t;
    typedef logic [2:0] tmr1_rate_t;
    typedef enum logic [1:0] {
        TMR1_BND_256 = 2'b00,
        TMR1_BND_64 = 2'b01,
        TMR1_BND_32 = 2'b10,
        TMR1_BND_16 = 2'b11
    } tmr1_bound_e;
endpackage : tmr1_pkg

// File: core/tmr1_prescale.sv
`timescale 1ns/10ps
`default_nettype none
module tmr1_prescale
    import tmr1_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire tmr1_rate_t rate_i,
    output logic tick_o
);
    tmr1_byte_t div;
    tmr1_byte_t mask;

    // ==========================================================
    // Free divider, cleared while idle so the first period is full
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div <= 8'h00;
        end else if (ce_i) begin
            if (run_i) begin
                div <= div + 8'h01;
            end else begin
                div <= 8'h00;
            end
        end
    end

    // Code 000 divides by 256, each step halves down to 2
    assign mask = 8'hFF >> rate_i;
    assign tick_o = run_i && ((div & mask) == mask);

    div2_tick_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ce_i && run_i && rate_i == 3'h7 && tick_o
            ##1 ce_i && run_i && $stable(rate_i)) |-> !tick_o)
        else $error("divide-by-2 tick repeated");
endmodule : tmr1_prescale
`default_nettype wire

// File: tb/tmr1_event_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Event pin source, idles high like a pulled-up pin
module tmr1_event_src (
    input wire logic clk_i,
    output logic pin_o
);
    initial pin_o = 1'b1;
    // Each level held 4 clocks, twice the minimum the sync needs
    task automatic fall(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask : fall
endmodule : tmr1_event_src
`default_nettype wire

// File: tb/tmr1_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmr1_regs.svh"
// ==========================================================
// Bench for the timer block
module tmr1_top_tb_top;
    import tmr1_pkg::*;
    localparam tmr1_byte_t MD = `TMR1_MODE_IDX;
    localparam tmr1_byte_t CN = `TMR1_COUNT_IDX;
    localparam tmr1_byte_t RL = `TMR1_RELOAD_IDX;
    localparam tmr1_byte_t ST = `TMR1_STATUS_IDX;
    logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, ce = 1;
    logic gpio_d = 0, gpio_oe = 0;
    tmr1_addr_t paddr = '0;
    tmr1_word_t pwdata = '0, prdata, lfsr_st = 32'heba5;
    logic pready, pslverr, pin, wave, wave_oe, tflag, eflag, tpulse;
    int bad_count = 0, total_checks = 0;
    logic [32:0] expq[$];
    int bnd[4] = '{256, 64, 32, 16};
    always #10 clk = ~clk;
    tmr1_top dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr),
        .EVENT_PORT_PIN_I(pin), .GPIO_DATA_I(gpio_d),
        .GPIO_OE_I(gpio_oe), .WAVE_OUTPUT_PIN_O(wave),
        .WAVE_OUTPUT_PIN_OE_O(wave_oe),
        .TIMER_ONE_REQUEST_FLAG_O(tflag),
        .EVENT_PIN_REQUEST_FLAG_O(eflag), .TIMEOUT_PULSE_O(tpulse));
    tmr1_event_src ev (.clk_i(clk), .pin_o(pin));
    // ==========================================================
    // Helpers
    function automatic tmr1_word_t rnd();
        lfsr_st = {lfsr_st[30:0],
            lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
        return lfsr_st;
    endfunction : rnd
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic fail;
        bad_count++;
        print_verdict();
    endtask : fail
    task automatic check(input string what, input logic [32:0] seen,
                         input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until pready is seen, released after that edge
    task automatic apb(input logic wr, input tmr1_byte_t idx,
                       input tmr1_byte_t d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= tmr1_addr_t'({idx, 2'b00});
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) fail();
        end while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input tmr1_byte_t idx, input tmr1_byte_t d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input tmr1_byte_t idx, input tmr1_byte_t e,
                      input logic err);
        expq.push_back({err, 24'h0, e});
        apb(1'b0, idx, 8'h00);
    endtask : rd
    // Returns the cycles up to the next time-out pulse
    task automatic wait1(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
            if (c > 70000) fail();
        end while (tpulse !== 1'b1);
    endtask : wait1
    // Returns the gap between the last two of three pulses
    task automatic wait3(output int c);
        repeat (3) wait1(c);
    endtask : wait3
    task automatic pin_is(input logic oe, input logic lv);
        repeat (3) @(negedge clk);
        check("wave pin", {31'h0, wave_oe, wave}, {31'h0, oe, lv});
    endtask : pin_is
    // ==========================================================
    // Read monitor: oldest note against each answered read
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr) begin
            if (expq.size() == 0) check("read queue", 33'h1, 33'h0);
            else check("read", {pslverr, prdata}, expq.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail();
    end
    // ==========================================================
    // Scenarios
    initial begin
        tmr1_word_t v;
        int c;
        int i;
        logic w;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(MD, 8'h00, 0);
        rd(CN, 8'h00, 0);
        rd(RL, 8'h00, 0);
        rd(8'h10, 8'h00, 1);
        v = rnd();
        wr(CN, v[7:0]);
        rd(CN, v[7:0], 0);
        // Reload of FF makes every tick an overflow
        wr(RL, 8'hFF);
        wr(CN, 8'hFF);
        for (i = 0; i < 8; i++) begin
            wr(MD, {1'b1, 3'(i), 4'b0100});
            wait3(c);
            check("rate period", 33'(c), 33'(1 << (8 - i)));
        end
        wr(MD, 8'h04);
        rd(ST, 8'h01, 0);
        wr(CN, 8'h10);
        wr(ST, 8'h01);
        repeat (600) @(posedge clk);
        rd(CN, 8'h10, 0);
        rd(ST, 8'h00, 0);
        check("timer flag", {32'h0, tflag}, 33'h0);
        // Event counting with reload 80
        wr(RL, 8'h80);
        wr(CN, 8'hFE);
        wr(MD, 8'h8C);
        repeat (600) @(posedge clk);
        rd(CN, 8'hFE, 0);
        ev.fall(1);
        rd(CN, 8'hFF, 0);
        // Clock enable low freezes the sync chain, so the edge is lost
        ce <= 1'b0;
        ev.fall(1);
        ce <= 1'b1;
        rd(CN, 8'hFF, 0);
        ev.fall(1);
        rd(CN, 8'h80, 0);
        rd(ST, 8'h01, 0);
        // Without reload the wrap lands on zero
        wr(MD, 8'h88);
        wr(CN, 8'hFF);
        ev.fall(1);
        rd(CN, 8'h00, 0);
        wr(MD, 8'h00);
        wr(ST, 8'h03);
        ev.fall(1);
        rd(ST, 8'h02, 0);
        check("event flag", {32'h0, eflag}, 33'h1);
        // PWM boundaries with reload 8
        wr(RL, 8'h08);
        wr(CN, 8'h08);
        for (i = 0; i < 4; i++) begin
            wr(MD, {4'b1111, 1'b0, 2'(i), 1'b1});
            wait3(c);
            check("pwm period", 33'(c), 33'(2 * (bnd[i] - 8)));
        end
        wr(MD, 8'h81);
        wr(CN, 8'h00);
        pin_is(1'b1, 1'b1);
        wr(RL, 8'h20);
        wr(CN, 8'h10);
        pin_is(1'b1, 1'b0);
        wr(CN, 8'hFF);
        // One overflow is enough to move the buffer to active
        wait1(c);
        wr(CN, 8'h10);
        pin_is(1'b1, 1'b1);
        // Toggle output, then plain port data
        wr(RL, 8'hFF);
        wr(MD, 8'hF6);
        wait3(c);
        w = wave;
        for (i = 0; i < 4; i++) begin
            wait3(c);
            w = ~w;
            check("toggle", {32'h0, wave}, {32'h0, w});
        end
        wr(MD, 8'hF4);
        for (i = 0; i < 3; i++) begin
            v = rnd();
            @(posedge clk);
            gpio_d <= v[0];
            gpio_oe <= v[1];
            pin_is(v[1], v[0]);
        end
        print_verdict();
    end
endmodule : tmr1_top_tb_top
`default_nettype wire
